// ---- rtl/sle_pkg.sv ----
/*
 scheme logic element library: constants, modes, register map and state types.
 assumes one system clock at 40 MHz; element logic advances once per scan tick.
*/
package sle_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int N_CTRL = 32;
   localparam int N_FKEY = 8;
   localparam int N_PROT = 8;
   localparam int N_GATE = 4;
   localparam int N_LED = 2;
   localparam int N_AUX = 4;
   localparam int N_CON = 4;
   localparam int N_ELEM = N_AUX + N_CON;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int SCAN_TIME_US = 1000;
   localparam int SCAN_CYCLES_DEF = SCAN_TIME_US * CLK_MHZ;

   // index of the fault recorder trigger signal in the signal map
   localparam int SIG_FAULT_REC = 144;
   localparam int FREC_GATE = 3;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL_MODE = 8'h00;
   localparam logic [7:0] A_CTRL_OPERATE = 8'h04;
   localparam logic [7:0] A_CTRL_RESET = 8'h08;
   localparam logic [7:0] A_CTRL_STATE = 8'h0c;
   localparam logic [7:0] A_FKEY_MODE = 8'h10;
   localparam logic [7:0] A_LED_CFG = 8'h14;
   localparam logic [7:0] A_LATCH_RESET = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1c;
   localparam logic [1:0] REGION_GATE = 2'h1;
   localparam logic [1:0] REGION_TMR = 2'h2;
   localparam logic [1:0] G_CFG = 2'h0;
   localparam logic [1:0] G_MASK = 2'h1;
   localparam logic [1:0] G_INV = 2'h2;

   // gate configuration fields
   localparam int GC_TYPE_LSB = 0;
   localparam int GC_INV_BIT = 2;
   localparam int GC_THR_LSB = 8;
   localparam int GC_W = 14;
   // latch reset fields
   localparam int LR_CON_LSB = 4;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      GATE_AND = 2'h0,
      GATE_OR = 2'h1,
      GATE_PROG = 2'h2
   } sle_gate_e;

   typedef enum logic [2:0] {
      MODE_PICKUP = 3'h0,
      MODE_DROPOFF = 3'h1,
      MODE_DWELL = 3'h2,
      MODE_PULSE = 3'h3,
      MODE_PUDO = 3'h4,
      MODE_STRAIGHT = 3'h5,
      MODE_LATCH = 3'h6
   } sle_mode_e;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic out;
      logic prev;
      logic [15:0] cnt;
   } sle_elem_s;

   typedef struct packed {
      logic [15:0] scan_cnt;
      logic tick;
      logic [N_CTRL-1:0] ctrl_mode;
      logic [N_CTRL-1:0] ctrl_pend;
      logic [N_CTRL-1:0] ctrl_sig;
      logic [N_FKEY-1:0] fkey_mode;
      logic [N_FKEY-1:0] fkey_meta;
      logic [N_FKEY-1:0] fkey_s2;
      logic [N_FKEY-1:0] fkey_prev;
      logic [N_FKEY-1:0] fkey_sig;
      logic [N_PROT-1:0] prot_meta;
      logic [N_PROT-1:0] prot_s2;
      logic [N_LED-1:0] led_cfg;
      logic [N_LED-1:0] led_red;
      logic [N_LED-1:0] led_green;
      logic [N_CON-1:0] con_clr;
      logic [N_GATE-1:0][GC_W-1:0] gcfg;
      logic [N_GATE-1:0][31:0] gmask;
      logic [N_GATE-1:0][31:0] ginv;
      logic [N_GATE-1:0] gate_out;
      logic [N_ELEM-1:0][2:0] tmode;
      logic [N_ELEM-1:0][31:0] ttime;
      logic frec;
      logic frec_start;
      logic [31:0] rdata;
   } sle_state_s;

endpackage

// ---- rtl/sle_elem_if.sv ----
/*
 connection between the scheme logic core and one timer or contact conditioner.
 assumes the core drives settings and input; the element answers with its output.
*/
`timescale 1ns/100ps
interface sle_elem_if;
   logic tick;
   logic in;
   logic [2:0] mode;
   logic [15:0] t_pu;
   logic [15:0] t_do;
   logic clr;
   logic out;

   // timer side
   modport elem (input tick, input in, input mode, input t_pu, input t_do, input clr, output out);
   // core side
   modport core (output tick, output in, output mode, output t_pu, output t_do, output clr,
      input out);
endinterface

// ---- rtl/sle_timer.sv ----
/*
 one timer or contact conditioner element, advanced once per scan tick.
 assumes times are counted in scan ticks and settings stay stable while in use.
*/
`timescale 1ns/100ps
module sle_timer
   import sle_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // core connection
   sle_elem_if.elem e
);

   sle_elem_s s;
   sle_elem_s next_s;

   // ----------------------------------------------------------------
   // element behaviour
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] pu;
      logic [15:0] dly;
      pu = (e.mode == MODE_DROPOFF) ? 16'h0000 : e.t_pu;
      dly = (e.mode == MODE_PICKUP) ? 16'h0000 : e.t_do;
      next_s = s;
      // lockout release outside the tick; a live input keeps it sealed
      if (e.clr && (e.mode == MODE_LATCH) && !e.in) begin
         next_s.out = 1'b0;
      end
      if (e.tick) begin
         next_s.prev = e.in;
         case (e.mode)
            MODE_PICKUP, MODE_DROPOFF, MODE_PUDO: begin
               if (!s.out) begin
                  if (!e.in) begin
                     next_s.cnt = 16'h0000;
                  end else if ((17'(s.cnt) + 17'h00001) >= 17'(pu)) begin
                     next_s.out = 1'b1;
                     next_s.cnt = 16'h0000;
                  end else begin
                     next_s.cnt = s.cnt + 16'h0001;
                  end
               end else begin
                  if (e.in) begin
                     next_s.cnt = 16'h0000;
                  end else if ((17'(s.cnt) + 17'h00001) >= 17'(dly)) begin
                     next_s.out = 1'b0;
                     next_s.cnt = 16'h0000;
                  end else begin
                     next_s.cnt = s.cnt + 16'h0001;
                  end
               end
            end
            MODE_DWELL: begin
               if (!s.out) begin
                  if (e.in) begin
                     next_s.out = 1'b1;
                     next_s.cnt = 16'h0001;
                  end
               end else if (!e.in && (s.cnt >= e.t_pu)) begin
                  next_s.out = 1'b0;
               end else if (s.cnt < e.t_pu) begin
                  next_s.cnt = s.cnt + 16'h0001;
               end
            end
            MODE_PULSE: begin
               if (!s.out) begin
                  if (e.in && !s.prev) begin
                     next_s.out = 1'b1;
                     next_s.cnt = 16'h0001;
                  end
               end else if (s.cnt >= e.t_pu) begin
                  next_s.out = 1'b0;
               end else begin
                  next_s.cnt = s.cnt + 16'h0001;
               end
            end
            MODE_LATCH: begin
               // a release in the tick cycle is kept; a live input still seals
               next_s.out = next_s.out | e.in;
            end
            default: begin
               next_s.out = e.in;
               next_s.cnt = 16'h0000;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign e.out = s.out;

endmodule // sle_timer

// ---- rtl/sle_top.sv ----
/*
 scheme logic element library: control inputs, function keys, gates, led and
 contact conditioners, auxiliary timers and the fault record trigger.
 assumes a plain register port driven from clk_sys and asynchronous pins for keys
 and protection signals.
*/
// The register addresses and the plain strobed port were left to the implementer.
// What this block does
// - thirty-two control inputs, each its own signal
// - per input latched or pulsed setting
// - toggled key inverts signal each press
// - normal key active only while held
// - fault record starts on trigger signal
// - each led drives a lit status signal
// - each contact drives an energised status signal
// - green, red, both gives yellow
// - led latching or following its inputs
// - contact conditioner has seven modes
// - straight passes input, latching seals in
// - auxiliary timer has five modes
// - separate pick-up, drop-off times; unused ignored
// - and gate needs all inputs true
// - or gate needs one input true
// - programmable gate counts true against threshold
// - optional gate output inversion
// - only gate input connections may invert
`timescale 1ns/100ps
module sle_top
   import sle_pkg::*;
#(
   parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // pins
   input wire logic [N_FKEY-1:0] fkey,
   input wire logic [N_PROT-1:0] prot_sig,
   // internal logic signals
   output logic [N_CTRL-1:0] ctrl_sig,
   output logic [N_FKEY-1:0] fkey_sig,
   output logic [N_GATE-1:0] gate_out,
   output logic [N_AUX-1:0] aux_timer_out,
   output logic [N_CON-1:0] contact_out,
   output logic [N_LED-1:0] led_red,
   output logic [N_LED-1:0] led_green,
   output logic fault_record_request,
   output logic fault_record_start
);

   localparam logic [15:0] SCAN_LAST = 16'(SCAN_CYCLES - 1);

   sle_state_s s;
   sle_state_s next_s;
   logic [N_ELEM-1:0] elem_out;
   logic [31:0] pool;

   sle_elem_if e[N_ELEM]();

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [5:0] sle_count(input logic [31:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 32; i++) begin
         c = c + 6'(v[i]);
      end
      return c;
   endfunction

   // one gate: inversion only on connected inputs, then function and output invert
   function automatic logic sle_gate(input logic [GC_W-1:0] cfg, input logic [31:0] p,
      input logic [31:0] msk, input logic [31:0] inv);
      logic [31:0] v;
      logic r;
      v = (p ^ inv) & msk;
      case (cfg[GC_TYPE_LSB +: 2])
         GATE_AND: r = (msk != 32'h00000000) && (v == msk);
         GATE_OR: r = |v;
         GATE_PROG: r = sle_count(v) >= cfg[GC_THR_LSB +: 6];
         default: r = 1'b0;
      endcase
      return r ^ cfg[GC_INV_BIT];
   endfunction

   // ----------------------------------------------------------------
   // signal pool seen by every gate
   // ----------------------------------------------------------------
   assign pool = {s.ctrl_sig[7:0], s.prot_s2, s.fkey_sig, elem_out[N_AUX +: N_CON],
      s.led_red | s.led_green, elem_out[1:0]};

   // ----------------------------------------------------------------
   // element connections
   // ----------------------------------------------------------------
   for (genvar i = 0; i < N_ELEM; i++) begin : g_elem
      assign e[i].tick = s.tick;
      assign e[i].in = s.gate_out[i % N_GATE];
      assign e[i].t_pu = s.ttime[i][15:0];
      assign e[i].t_do = s.ttime[i][31:16];
      if (i < N_AUX) begin : g_aux
         // auxiliary timers have no straight or latching mode
         assign e[i].mode = (s.tmode[i] > MODE_PUDO) ? MODE_PICKUP : s.tmode[i];
         assign e[i].clr = 1'b0;
      end else begin : g_con
         assign e[i].mode = s.tmode[i];
         assign e[i].clr = s.con_clr[i - N_AUX];
      end
      assign elem_out[i] = e[i].out;
      sle_timer sle_timer_i (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .e(e[i])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_gate;
      logic wr_tmr;
      logic [1:0] gi;
      logic [2:0] ti;
      logic [N_LED-1:0] led_clr;
      logic [N_LED-1:0] red_in;
      logic [N_LED-1:0] green_in;
      wr_gate = wr && (addr[7:6] == REGION_GATE);
      wr_tmr = wr && (addr[7:6] == REGION_TMR);
      gi = addr[5:4];
      ti = addr[5:3];
      led_clr = '0;
      for (int k = 0; k < N_LED; k++) begin
         red_in[k] = s.gate_out[2 * k];
         green_in[k] = s.gate_out[2 * k + 1];
      end
      next_s = s;
      next_s.con_clr = '0;
      next_s.frec_start = 1'b0;

      // pin synchronisers
      next_s.fkey_meta = fkey;
      next_s.fkey_s2 = s.fkey_meta;
      next_s.prot_meta = prot_sig;
      next_s.prot_s2 = s.prot_meta;

      // scan tick generator
      next_s.tick = 1'b0;
      if (s.scan_cnt >= SCAN_LAST) begin
         next_s.scan_cnt = 16'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.scan_cnt = s.scan_cnt + 16'h0001;
      end

      // register writes
      if (wr) begin
         case (addr)
            A_CTRL_MODE: next_s.ctrl_mode = wdata;
            A_FKEY_MODE: next_s.fkey_mode = wdata[N_FKEY-1:0];
            A_LED_CFG: next_s.led_cfg = wdata[N_LED-1:0];
            A_LATCH_RESET: begin
               led_clr = wdata[N_LED-1:0];
               next_s.con_clr = wdata[LR_CON_LSB +: N_CON];
            end
            default: begin
            end
         endcase
      end
      if (wr_gate) begin
         case (addr[3:2])
            G_CFG: next_s.gcfg[gi] = wdata[GC_W-1:0];
            G_MASK: next_s.gmask[gi] = wdata;
            G_INV: next_s.ginv[gi] = wdata;
            default: begin
            end
         endcase
      end
      if (wr_tmr) begin
         if (addr[2]) begin
            next_s.ttime[ti] = wdata;
         end else begin
            next_s.tmode[ti] = wdata[2:0];
         end
      end

      // control inputs: latched ones clear by reset register, set wins
      if (wr && (addr == A_CTRL_RESET)) begin
         next_s.ctrl_sig = s.ctrl_sig & ~(wdata & s.ctrl_mode);
      end
      if (s.tick) begin
         next_s.ctrl_sig = (next_s.ctrl_sig & s.ctrl_mode) | s.ctrl_pend;
         next_s.ctrl_pend = '0;
      end
      if (wr && (addr == A_CTRL_OPERATE)) begin
         next_s.ctrl_pend = next_s.ctrl_pend | wdata;
      end

      // led conditioners: clear first, then the tick's inputs
      next_s.led_red = s.led_red & ~led_clr;
      next_s.led_green = s.led_green & ~led_clr;
      if (s.tick) begin
         for (int k = 0; k < N_LED; k++) begin
            if (s.led_cfg[k]) begin
               next_s.led_red[k] = next_s.led_red[k] | red_in[k];
               next_s.led_green[k] = next_s.led_green[k] | green_in[k];
            end else begin
               next_s.led_red[k] = red_in[k];
               next_s.led_green[k] = green_in[k];
            end
         end
      end

      // scan evaluation of keys, gates and trigger
      if (s.tick) begin
         next_s.fkey_prev = s.fkey_s2;
         for (int k = 0; k < N_FKEY; k++) begin
            if (s.fkey_mode[k]) begin
               next_s.fkey_sig[k] = s.fkey_sig[k] ^ (s.fkey_s2[k] & ~s.fkey_prev[k]);
            end else begin
               next_s.fkey_sig[k] = s.fkey_s2[k];
            end
         end
         for (int g = 0; g < N_GATE; g++) begin
            next_s.gate_out[g] = sle_gate(s.gcfg[g], pool, s.gmask[g], s.ginv[g]);
         end
         next_s.frec = s.gate_out[FREC_GATE];
         next_s.frec_start = s.gate_out[FREC_GATE] & ~s.frec;
      end

      // register reads, data one cycle later
      next_s.rdata = 32'h00000000;
      if (rd) begin
         case (addr[7:6])
            REGION_GATE: begin
               case (addr[3:2])
                  G_CFG: next_s.rdata = 32'(s.gcfg[gi]);
                  G_MASK: next_s.rdata = s.gmask[gi];
                  G_INV: next_s.rdata = s.ginv[gi];
                  default: next_s.rdata = 32'h00000000;
               endcase
            end
            REGION_TMR: begin
               next_s.rdata = addr[2] ? s.ttime[ti] : 32'(s.tmode[ti]);
            end
            default: begin
               case (addr)
                  A_CTRL_MODE: next_s.rdata = s.ctrl_mode;
                  A_CTRL_STATE: next_s.rdata = s.ctrl_sig;
                  A_FKEY_MODE: next_s.rdata = 32'(s.fkey_mode);
                  A_LED_CFG: next_s.rdata = 32'(s.led_cfg);
                  A_STATUS: next_s.rdata = {4'h0, s.fkey_sig, 3'h0, s.frec, s.gate_out,
                     elem_out, s.led_green, s.led_red};
                  default: next_s.rdata = 32'h00000000;
               endcase
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata = s.rdata;
   assign ctrl_sig = s.ctrl_sig;
   assign fkey_sig = s.fkey_sig;
   assign gate_out = s.gate_out;
   assign aux_timer_out = elem_out[N_AUX-1:0];
   assign contact_out = elem_out[N_AUX +: N_CON];
   assign led_red = s.led_red;
   assign led_green = s.led_green;
   assign fault_record_request = s.frec;
   assign fault_record_start = s.frec_start;

endmodule // sle_top

// ---- tb/sle_partner.sv ----
/*
 far side model: operator keys and protection functions driving the pins.
 assumes the bench raises requests; slow adds a lag of two more clocks.
*/
`timescale 1ns/100ps
module sle_partner (
   // clock
   input wire logic clk_sys,
   // requests from the bench
   input wire logic [7:0] key_req,
   input wire logic [7:0] prot_req,
   input wire logic slow,
   // pins toward the block
   output logic [7:0] fkey,
   output logic [7:0] prot_sig
);
   logic [2:0][15:0] lag = '0;

   // lag line: a prompt answer takes the first stage, a slow one the last
   always @(posedge clk_sys) begin
      lag <= {lag[1:0], key_req, prot_req};
   end
   assign {fkey, prot_sig} = slow ? lag[2] : lag[0];
endmodule // sle_partner

// ---- tb/sle_checker.sv ----
/*
 assertions on the ports of the scheme logic top.
 assumes the scan length of eight clocks used by the bench.
*/
`timescale 1ns/100ps
module sle_checker
   import sle_pkg::*;
#(
   parameter int SCAN_CYCLES = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register port
   input wire logic [7:0] addr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // logic signals
   input wire logic [N_CTRL-1:0] ctrl_sig,
   input wire logic [N_GATE-1:0] gate_out,
   input wire logic [N_AUX-1:0] aux_timer_out,
   input wire logic [N_CON-1:0] contact_out,
   input wire logic [N_LED-1:0] led_red,
   input wire logic [N_LED-1:0] led_green,
   input wire logic fault_record_request,
   input wire logic fault_record_start
);
   logic [15:0] wait_cnt;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // cycles since the trigger rose without a record start
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) wait_cnt <= 16'h0;
      else if (fault_record_start) wait_cnt <= 16'h0;
      else if ($rose(fault_record_request) || wait_cnt != 16'h0) wait_cnt <= wait_cnt + 16'h1;
   end

   sequence s_rd_status;
      rd && addr == A_STATUS;
   endsequence
   sequence s_rd_ctrl;
      rd && addr == A_CTRL_STATE;
   endsequence

   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_unmapped_zero: assert property (rd && addr == 8'hfc |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (s_rd_ctrl |=> rdata == $past(ctrl_sig))
      else $error("control state read differs from control signals");
   chk_status_gates: assert property (s_rd_status |=>
      rdata[16:12] == {$past(fault_record_request), $past(gate_out)})
      else $error("status gate field differs from gate outputs");
   chk_status_leds: assert property (s_rd_status |=>
      rdata[3:0] == {$past(led_green), $past(led_red)})
      else $error("status led field differs from led drives");
   chk_status_contacts: assert property (s_rd_status |=>
      rdata[11:4] == {$past(contact_out), $past(aux_timer_out)})
      else $error("status element field differs from element outputs");
   // levels stand a whole scan of eight clocks
   chk_gate_scan: assert property ($changed(gate_out) |=> $stable(gate_out) [*7])
      else $error("gate output changed inside a scan");
   chk_aux_scan: assert property ($changed(aux_timer_out) |=> $stable(aux_timer_out) [*7])
      else $error("timer output changed inside a scan");
   chk_start_pulse: assert property (fault_record_start |=> !fault_record_start)
      else $error("record start longer than one clock");
   chk_start_bound: assert property (int'(wait_cnt) <= 2 * SCAN_CYCLES + 2)
      else $error("record start missing after trigger");
endmodule // sle_checker

bind sle_top sle_checker #(.SCAN_CYCLES(SCAN_CYCLES)) sle_checker_i (
   .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .rd(rd), .rdata(rdata),
   .ctrl_sig(ctrl_sig), .gate_out(gate_out), .aux_timer_out(aux_timer_out),
   .contact_out(contact_out), .led_red(led_red), .led_green(led_green),
   .fault_record_request(fault_record_request), .fault_record_start(fault_record_start));

// ---- tb/sle_top_tb.sv ----
/*
 self-checking bench for the scheme logic element library.
 assumes a scan of eight clocks and the partner model on the pins.
*/
`timescale 1ns/100ps
module sle_top_tb
   import sle_pkg::*;
;
   localparam int SC = 8;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] key_req = 8'h0;
   logic [7:0] prot_req = 8'h0;
   logic slow = 1'b0;
   logic [31:0] rdata;
   logic [7:0] fkey;
   logic [7:0] prot_sig;
   logic [N_CTRL-1:0] ctrl_sig;
   logic [N_FKEY-1:0] fkey_sig;
   logic [N_GATE-1:0] gate_out;
   logic [N_AUX-1:0] aux_out;
   logic [N_CON-1:0] con_out;
   logic [N_LED-1:0] led_red;
   logic [N_LED-1:0] led_green;
   logic frec_req;
   logic frec_start;
   logic [63:0] notes[$];
   int failures = 0;
   int cmp_count = 0;
   int starts = 0;

   sle_top #(.SCAN_CYCLES(SC)) sle_top_i (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fkey(fkey), .prot_sig(prot_sig),
      .ctrl_sig(ctrl_sig), .fkey_sig(fkey_sig), .gate_out(gate_out),
      .aux_timer_out(aux_out), .contact_out(con_out), .led_red(led_red),
      .led_green(led_green), .fault_record_request(frec_req),
      .fault_record_start(frec_start));
   sle_partner sle_partner_i (.clk_sys(clk_sys), .key_req(key_req), .prot_req(prot_req),
      .slow(slow), .fkey(fkey), .prot_sig(prot_sig));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // note the masked expectation, then issue the read
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys);
      notes.push_back({m, e & m});
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
   endtask
   task automatic scans(input int n);
      repeat (n * SC) @(posedge clk_sys);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, monitor, watchdog
   // ----------------------------------------------------------------
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // read answers compared with the oldest note
   always @(posedge clk_sys) begin
      logic [63:0] n;
      if (rd_d) begin
         n = notes.pop_front();
         chk(rdata & n[63:32], n[31:0]);
      end
      rd_d <= rd;
      if (frec_start === 1'b1) starts++;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      logic [31:0] m;
      logic [2:0] p;
      logic g;
      int ty, th, c;
      void'($urandom(32'h5b3e48d8));
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_chk(A_CTRL_MODE, '1, 32'h0);
      rd_chk(A_STATUS, '1, 32'h0);
      rd_chk(8'hfc, '1, 32'h0);
      // gate 0 on three protection signals, one link and one loose bit inverted
      wr_reg(8'h44, 32'h0007_0000);
      wr_reg(8'h48, 32'h0014_0000);
      repeat (12) begin
         p = 3'($urandom);
         ty = $urandom_range(2);
         th = $urandom_range(3, 1);
         g = 1'($urandom);
         wr_reg(8'h40, 32'(th << 8) | {29'h0, g, 2'(ty)});
         prot_req <= {5'h0, p};
         slow <= 1'($urandom);
         scans(4);
         c = $countones(p ^ 3'h4);
         g = g ^ (ty == 0 ? c == 3 : ty == 1 ? c > 0 : c >= th);
         rd_chk(A_STATUS, 32'h1000, {19'h0, g, 12'h0});
      end
      // control inputs, bit 0 pulsed
      m = $urandom & 32'hffff_fffe;
      wr_reg(A_CTRL_MODE, m);
      rd_chk(A_CTRL_MODE, '1, m);
      wr_reg(A_CTRL_OPERATE, '1);
      c = 0;
      while (ctrl_sig[0] !== 1'b1 && c < 4 * SC) begin
         @(negedge clk_sys);
         c++;
      end
      c = 0;
      while (ctrl_sig[0] === 1'b1 && c < 4 * SC) begin
         @(negedge clk_sys);
         c++;
      end
      chk(32'(c), 32'(SC));
      scans(2);
      rd_chk(A_CTRL_STATE, '1, m);
      wr_reg(A_CTRL_RESET, '1);
      scans(2);
      rd_chk(A_CTRL_STATE, '1, 32'h0);
      // keys 0..3 toggled, 4..7 normal
      wr_reg(A_FKEY_MODE, 32'h0f);
      for (int i = 0; i < 2; i++) begin
         key_req <= 8'hff;
         scans(3);
         rd_chk(A_STATUS, 32'h0ff0_0000, i ? 32'h0f00_0000 : 32'h0ff0_0000);
         key_req <= 8'h00;
         scans(3);
         rd_chk(A_STATUS, 32'h0ff0_0000, i ? 32'h0 : 32'h00f0_0000);
      end
      // aux 1 and contact 1 behind gate 1, every mode
      wr_reg(8'h50, 32'h1);
      wr_reg(8'h54, 32'h0010_0000);
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h88, 32'(i));
         wr_reg(8'h8c, 32'h0002_0002);
         wr_reg(8'ha8, 32'(i));
         wr_reg(8'hac, i > 4 ? 32'hffff_ffff : 32'h0002_0002);
         prot_req[4] <= 1'b1;
         scans(7);
         rd_chk(A_STATUS, 32'h220, i == 3 ? 32'h0 : 32'h220);
         prot_req[4] <= 1'b0;
         scans(7);
         rd_chk(A_STATUS, 32'h220, i == 6 ? 32'h200 : 32'h0);
         wr_reg(A_LATCH_RESET, 32'h20);
         scans(1);
      end
      // led 0: red from gate 0, green from gate 1
      wr_reg(8'h40, 32'h1);
      wr_reg(8'h44, 32'h0020_0000);
      wr_reg(8'h48, 32'h0);
      for (int i = 0; i < 4; i++) begin
         prot_req[5:4] <= 2'(i);
         scans(4);
         rd_chk(A_STATUS, 32'h5, {29'h0, 1'(i), 1'b0, 1'(i >> 1)});
      end
      wr_reg(A_LED_CFG, 32'h1);
      scans(2);
      prot_req[5:4] <= 2'h0;
      scans(4);
      rd_chk(A_STATUS, 32'h5, 32'h5);
      wr_reg(A_LATCH_RESET, 32'h1);
      scans(2);
      rd_chk(A_STATUS, 32'h5, 32'h0);
      // fault record trigger on gate 3
      wr_reg(8'h70, 32'h1);
      wr_reg(8'h74, 32'h0040_0000);
      prot_req[6] <= 1'b1;
      scans(4);
      rd_chk(A_STATUS, 32'h1_8000, 32'h1_8000);
      prot_req[6] <= 1'b0;
      scans(4);
      rd_chk(A_STATUS, 32'h1_0000, 32'h0);
      chk(32'(starts), 32'h1);
      scans(1);
      report_and_stop();
   end
endmodule // sle_top_tb
